// ===== watchdog_timer_secure_clear_tb_top.sv
// Purpose: self-checking bench for the watchdog timer block
// Assumes: bus strobes driven just after the rising clock edge
// Notes:   every scenario starts from its own reset
`default_nettype none
module watchdog_timer_secure_clear_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // stimulus signals and counters
   logic        i_mclk = 1'b0; // 10 MHz bus clock
   logic        i_rst  = 1'b1; // sync reset
   logic [31:0] i_addr = 32'h0;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr   = 1'b0;
   logic        i_rd   = 1'b0;
   logic [31:0] o_rdata;       // read data, cycle after strobe
   logic        o_irq;
   logic        o_chip_reset;
   int          n_errors   = 0;
   int          n_compared = 0;
   // half period 50 ns
   always #50 i_mclk = ~i_mclk;
   wdt_timer #(.CNT_W(16)) DUT (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_addr      (i_addr),
      .i_wdata     (i_wdata),
      .i_wr        (i_wr),
      .i_rd        (i_rd),
      .o_rdata     (o_rdata),
      .o_irq       (o_irq),
      .o_chip_reset(o_chip_reset)
   );
   // ==========================================================
   // shared tasks
   task automatic summarize();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // two edges of reset; first request may follow at once
   task automatic do_reset();
      i_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
   endtask
   // the trailing #1 keeps a following strobe out of this time step
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      check(o_rdata, exp);
   endtask
   // wait for irq (sel 0) or chip reset (sel 1) within lo..hi cycles
   task automatic wait_hi(input bit sel, input int lo, input int hi);
      int n;
      n = 0;
      while ((sel ? o_chip_reset : o_irq) !== 1'b1) begin
         @(posedge i_mclk);
         #1;
         n++;
         if (n > hi) begin
            n_errors++;
            $display("CHECK FAILED at %0t: wait limit", $time);
            summarize();
         end
      end
      n_compared++;
      if (n < lo) begin
         n_errors++;
         $display("CHECK FAILED at %0t: event too early", $time);
      end
   endtask
   // ==========================================================
   // scenarios
   task automatic s_regs();
      do_reset();
      rd_chk(wdt_pkg::CONFIG_ADDR, 32'h0);
      rd_chk(wdt_pkg::RELOAD_ADDR, 32'h0);
      rd_chk(wdt_pkg::VALUE_ADDR, 32'h0000FFFF);
      wr(wdt_pkg::SERVICE_ADDR, 32'h5A);
      rd_chk(wdt_pkg::SERVICE_ADDR, 32'h0);
      wr(32'hFFFF0370, 32'h1);
      rd_chk(32'hFFFF0370, 32'h0);
      wr(wdt_pkg::RELOAD_ADDR, 32'hFFFFABCD);
      rd_chk(wdt_pkg::RELOAD_ADDR, 32'h0000ABCD);
      // all fields but watchdog entry, reserved bits read 0
      wr(wdt_pkg::CONFIG_ADDR, 32'hFFFFFFDF);
      rd_chk(wdt_pkg::CONFIG_ADDR, 32'h000001DE);
   endtask
   // periodic up reload to 1, then free-running down must wrap
   task automatic s_wrap();
      do_reset();
      wr(wdt_pkg::RELOAD_ADDR, 32'h1);
      wr(wdt_pkg::CONFIG_ADDR, 32'h1C0);
      wait_hi(1'b0, 290, 320);
      wr(wdt_pkg::SERVICE_ADDR, 32'h0);
      check(o_irq, 1'b0);
      wr(wdt_pkg::CONFIG_ADDR, 32'h080);
      wait_hi(1'b0, 300, 620);
      rd_chk(wdt_pkg::VALUE_ADDR, 32'h0000FFFF);
   endtask
   // tick spacing measured by reading the count every cycle
   task automatic rate(input logic [31:0] cfg, input int per);
      logic [15:0] v;
      logic [15:0] p;
      int          t[3];
      int          k;
      int          n;
      do_reset();
      wr(wdt_pkg::CONFIG_ADDR, cfg);
      i_addr <= wdt_pkg::VALUE_ADDR;
      i_rd   <= 1'b1;
      @(posedge i_mclk);
      #1;
      p = o_rdata[15:0];
      k = 0;
      n = 0;
      while (k < 3) begin
         @(posedge i_mclk);
         #1;
         n++;
         v = o_rdata[15:0];
         if (v !== p) begin
            // up free-running wraps from all ones to zero
            if (k == 0 && cfg[8]) check(v, 32'h0);
            if (k == 2) check(v, cfg[8] ? p + 1 : p - 1);
            t[k] = n;
            k++;
         end
         p = v;
         if (n > 4 * per + 700) begin
            n_errors++;
            $display("CHECK FAILED at %0t: no tick", $time);
            summarize();
         end
      end
      i_rd <= 1'b0;
      n_compared++;
      if (t[2] - t[1] > per + 1 || t[2] - t[1] < per - 1) begin
         n_errors++;
         $display("CHECK FAILED at %0t: tick %0d", $time, t[2] - t[1]);
      end
   endtask
   task automatic s_stopped();
      do_reset();
      wr(wdt_pkg::CONFIG_ADDR, 32'h100);
      repeat (700) @(posedge i_mclk);
      rd_chk(wdt_pkg::VALUE_ADDR, 32'h0000FFFF);
      check(o_irq, 1'b0);
   endtask
   task automatic s_periodic();
      do_reset();
      wr(wdt_pkg::RELOAD_ADDR, 32'hFFFD);
      wr(wdt_pkg::CONFIG_ADDR, 32'h1C0);
      wait_hi(1'b0, 0, 700);
      rd_chk(wdt_pkg::VALUE_ADDR, 32'h0000FFFD);
      wr(wdt_pkg::SERVICE_ADDR, 32'h3C);
      check(o_irq, 1'b0);
   endtask
   // three ticks take load 2 through 1 and 0 to expiry
   task automatic s_expire(input bit opt);
      do_reset();
      wr(wdt_pkg::RELOAD_ADDR, 32'h2);
      wr(wdt_pkg::CONFIG_ADDR, opt ? 32'hA2 : 32'hA0);
      rd_chk(wdt_pkg::VALUE_ADDR, 32'h2);
      wr(wdt_pkg::CONFIG_ADDR, 32'h0);
      wr(wdt_pkg::RELOAD_ADDR, 32'h9);
      rd_chk(wdt_pkg::CONFIG_ADDR, opt ? 32'hA2 : 32'hA0);
      rd_chk(wdt_pkg::RELOAD_ADDR, 32'h2);
      wait_hi(!opt, 900, 915);
      check(opt ? o_chip_reset : o_irq, 1'b0);
   endtask
   // services spaced wider than one tick keep a short timeout alive
   task automatic s_service();
      do_reset();
      wr(wdt_pkg::RELOAD_ADDR, 32'h3);
      wr(wdt_pkg::CONFIG_ADDR, 32'hA0);
      for (int i = 0; i < 6; i++) begin
         repeat (500) @(posedge i_mclk);
         wr(wdt_pkg::SERVICE_ADDR, 32'(i));
         rd_chk(wdt_pkg::VALUE_ADDR, 32'h3);
      end
      check(o_chip_reset, 1'b0);
   endtask
   // seeded sequence, then a wrong value
   task automatic s_secure(input logic [7:0] seed);
      logic [7:0] seq[3];
      seq = '{8'hAA, 8'h37, 8'h6E};
      do_reset();
      wr(wdt_pkg::RELOAD_ADDR, 32'h100);
      wr(wdt_pkg::SERVICE_ADDR, {24'h0, seed});
      wr(wdt_pkg::CONFIG_ADDR, 32'hB0);
      if (seed == 8'h00) begin
         wr(wdt_pkg::SERVICE_ADDR, 32'h0);
         @(posedge i_mclk);
         #1;
         check(o_chip_reset, 1'b1);
      end else begin
         foreach (seq[i]) begin
            wr(wdt_pkg::SERVICE_ADDR, {24'h0, seq[i]});
            rd_chk(wdt_pkg::VALUE_ADDR, 32'h100);
            check(o_chip_reset, 1'b0);
         end
         wr(wdt_pkg::SERVICE_ADDR, 32'h66);
         @(posedge i_mclk);
         #1;
         check(o_chip_reset, 1'b1);
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      s_regs();
      rate(32'h080, 305);
      rate(32'h184, 4880);
      rate(32'h18C, 305);
      s_stopped();
      s_periodic();
      s_wrap();
      s_expire(1'b0);
      s_expire(1'b1);
      s_service();
      s_secure(8'hAA);
      s_secure(8'h00);
      summarize();
   end
endmodule
`default_nettype wire

// ===== wdt_lfsr.sv
// Purpose: expected service value generator for secure clear
// Assumes: seed loaded before watchdog entry
// Notes:   state has no bus read path on purpose
`default_nettype none
module wdt_lfsr (
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   input  wire logic       i_load,
   input  wire logic [7:0] i_seed,
   input  wire logic       i_adv,
   output var  logic [7:0] o_state
);
   // ==========================================================
   // state register
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_state <= wdt_pkg::LFSR_RST;
      end else if (i_load) begin
         o_state <= i_seed;                       // seed write
      end else if (i_adv) begin
         o_state <= wdt_pkg::lfsr_step(o_state);
      end
   end

   lfsr_step_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      i_adv && !i_load |=>
      o_state == ({$past(o_state[6:0]), 1'b0} ^
                  ($past(o_state[7]) ? 8'h63 : 8'h00)))
      else $error("lfsr did not advance with taps 0x63");
endmodule
`default_nettype wire

// ===== wdt_pkg.sv
// Purpose: shared constants for the watchdog timer block
// Assumes: 10 MHz bus clock, 32.768 kHz timer source rate
// Notes:   byte addresses, field positions, reset values, counts
`default_nettype none
package wdt_pkg;
   // ==========================================================
   // clocking
   localparam int unsigned CLK_HZ  = 10_000_000; // bus clock
   localparam int unsigned SRC_HZ  = 32_768;     // timer source
   // source tick period in bus cycles, rounded down
   localparam int unsigned SRC_DIV = CLK_HZ / SRC_HZ;
   localparam int unsigned SRC_W   = $clog2(SRC_DIV);

   // ==========================================================
   // register map (byte addresses)
   localparam logic [31:0] RELOAD_ADDR  = 32'hFFFF0360;
   localparam logic [31:0] VALUE_ADDR   = 32'hFFFF0364;
   localparam logic [31:0] CONFIG_ADDR  = 32'hFFFF0368;
   localparam logic [31:0] SERVICE_ADDR = 32'hFFFF036C;

   // ==========================================================
   // config fields
   localparam int unsigned CFG_W        = 9;
   localparam int unsigned CFG_UP       = 8;
   localparam int unsigned CFG_EN       = 7;
   localparam int unsigned CFG_PERIODIC = 6;
   localparam int unsigned CFG_WD       = 5;
   localparam int unsigned CFG_SECURE   = 4;
   localparam int unsigned CFG_PRE_HI   = 3;
   localparam int unsigned CFG_PRE_LO   = 2;
   localparam int unsigned CFG_IRQ_OPT  = 1;
   localparam logic [8:0]  CFG_MASK     = 9'h1FE; // bit 0 reserved
   localparam logic [8:0]  CFG_RST      = 9'h000;

   // prescale codes
   localparam logic [1:0]  PRE_DIV1     = 2'h0;
   localparam logic [1:0]  PRE_DIV16    = 2'h1;
   localparam logic [1:0]  PRE_DIV256   = 2'h2;
   localparam logic [7:0]  PRE_M1       = 8'h00;
   localparam logic [7:0]  PRE_M16      = 8'h0F;
   localparam logic [7:0]  PRE_M256     = 8'hFF;

   // ==========================================================
   // reset values and lfsr
   localparam logic [15:0] RELOAD_RST   = 16'h0000;
   localparam logic [15:0] VALUE_RST    = 16'hFFFF;
   localparam logic [15:0] VALUE_TOP    = 16'hFFFF;
   localparam logic [15:0] VALUE_ZERO   = 16'h0000;
   localparam logic [7:0]  LFSR_RST     = 8'h00;
   localparam logic [7:0]  LFSR_TAPS    = 8'h63;

   // one lfsr advance: shift left, fold taps if msb fell out
   function automatic logic [7:0] lfsr_step(input logic [7:0] s);
      lfsr_step = {s[6:0], 1'b0} ^ (s[7] ? LFSR_TAPS : 8'h00);
   endfunction
endpackage
`default_nettype wire

// ===== wdt_prescale.sv
// Purpose: timer source tick and 1/16/256 prescaler
// Assumes: single bus clock, source rate derived by division
// Notes:   prescale counter runs free; o_tick is one cycle
`default_nettype none
module wdt_prescale (
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   input  wire logic [1:0] i_sel,
   output var  logic       o_tick
);
   // ==========================================================
   // source divider
   logic [wdt_pkg::SRC_W-1:0] src_cnt_ff; // bus cycles in period
   logic                      src_tick;   // one source edge
   logic [7:0]                pre_cnt_ff; // source edges seen
   logic [7:0]                pre_mask;   // low bits that must be 1

   // code 11 falls back to divide by one
   function automatic logic [7:0] div_mask(input logic [1:0] sel);
      case (sel)
         wdt_pkg::PRE_DIV16:  div_mask = wdt_pkg::PRE_M16;
         wdt_pkg::PRE_DIV256: div_mask = wdt_pkg::PRE_M256;
         default:             div_mask = wdt_pkg::PRE_M1;
      endcase
   endfunction

   assign src_tick = (src_cnt_ff ==
                      wdt_pkg::SRC_W'(wdt_pkg::SRC_DIV - 1));
   assign pre_mask = div_mask(i_sel);

   // period counter for the 32 kHz source
   always_ff @(posedge i_mclk) begin
      if (i_rst || src_tick) begin
         src_cnt_ff <= '0;
      end else begin
         src_cnt_ff <= src_cnt_ff + 1'b1;
      end
   end

   // ==========================================================
   // prescaler
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         pre_cnt_ff <= 8'h00;
      end else if (src_tick) begin
         pre_cnt_ff <= pre_cnt_ff + 8'h01;
      end
   end

   // tick when the selected low bits are all ones
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_tick <= 1'b0;
      end else begin
         o_tick <= src_tick && ((pre_cnt_ff & pre_mask) == pre_mask);
      end
   end

   pre_div1_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      src_tick && (i_sel == 2'h3 || i_sel == 2'h0) |=> o_tick)
      else $error("divide by one missed a source edge");
endmodule
`default_nettype wire

// ===== wdt_timer.sv
// Purpose: general timer and watchdog with secure clear
// Assumes: synchronous strobes, read data one cycle later
// Notes:   o_chip_reset holds until i_rst is applied
//
// What this block does
// - config bit 8 selects up count
// - config bit 7 enables the timer
// - config bit 6 periodic, else free running
// - config bit 5 enters watchdog mode
// - config bit 4 enables secure clear
// - prescale 1, 16, 256; code 11 as 00
// - bit 1: watchdog expiry interrupts, not resets
// - service write clears irq or reloads watchdog
// - expected value from 8-bit lfsr
// - matching service reloads and advances lfsr
// - mismatching secure service resets chip at once
// - zero seed always forces reset
// - lfsr state is not readable
// - watchdog counts down from load value
// - watchdog mode locks load and config
// - load register is 16 bits
//
// Local design decision: the address-and-strobe port.
`default_nettype none
module wdt_timer #(
   parameter int unsigned CNT_W = 16  // counter and load width
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output var  logic [31:0] o_rdata,
   output var  logic        o_irq,
   output var  logic        o_chip_reset
);
   // ==========================================================
   // state and decode
   logic [wdt_pkg::CFG_W-1:0] cfg_ff;     // config register
   logic [CNT_W-1:0]          reload_ff;  // load value
   logic [CNT_W-1:0]          cnt_ff;     // live count
   logic [CNT_W-1:0]          nxt_cnt;    // next count
   logic                      expire;     // terminal count hit
   logic                      tick;       // prescaled count edge
   logic [7:0]                lfsr_q;     // expected service value
   logic                      wr_cfg;     // config write
   logic                      wr_load;    // load write
   logic                      wr_svc;     // service write
   logic                      wd_mode;    // watchdog active
   logic                      secure_on;  // secure clear active
   logic                      enter_wd;   // write that enters wd
   logic                      svc_ok;     // value matches lfsr
   logic                      good_svc;   // accepted wd service
   logic                      bad_svc;    // rejected wd service

   assign wr_cfg    = i_wr && (i_addr == wdt_pkg::CONFIG_ADDR);
   assign wr_load   = i_wr && (i_addr == wdt_pkg::RELOAD_ADDR);
   assign wr_svc    = i_wr && (i_addr == wdt_pkg::SERVICE_ADDR);
   assign wd_mode   = cfg_ff[wdt_pkg::CFG_WD];
   // secure clear counts only inside watchdog mode
   assign secure_on = wd_mode && cfg_ff[wdt_pkg::CFG_SECURE];
   assign enter_wd  = wr_cfg && !wd_mode &&
                      i_wdata[wdt_pkg::CFG_WD];
   // a zero state can never match, so zero always trips
   assign svc_ok    = (i_wdata[7:0] == lfsr_q) &&
                      (lfsr_q != 8'h00);
   assign good_svc  = wr_svc && wd_mode &&
                      (!secure_on || svc_ok);
   assign bad_svc   = wr_svc && secure_on && !svc_ok;

   // ==========================================================
   // helpers
   wdt_prescale u_prescale (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_sel  (cfg_ff[wdt_pkg::CFG_PRE_HI:wdt_pkg::CFG_PRE_LO]),
      .o_tick (tick)
   );

   // seed taken from service writes made outside watchdog mode
   wdt_lfsr u_lfsr (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_load  (wr_svc && !wd_mode),
      .i_seed  (i_wdata[7:0]),
      .i_adv   (good_svc && secure_on),
      .o_state (lfsr_q)
   );

   // ==========================================================
   // configuration and load registers
   // locked once in watchdog; only chip reset leaves it
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cfg_ff <= wdt_pkg::CFG_RST;
      end else if (wr_cfg && !wd_mode) begin
         cfg_ff <= i_wdata[wdt_pkg::CFG_W-1:0] & wdt_pkg::CFG_MASK;
      end
   end

   // 16-bit timeout value, also locked in watchdog mode
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         reload_ff <= wdt_pkg::RELOAD_RST;
      end else if (wr_load && !wd_mode) begin
         reload_ff <= i_wdata[CNT_W-1:0];
      end
   end

   // ==========================================================
   // counter next state
   always_comb begin
      nxt_cnt = cnt_ff;
      expire  = 1'b0;
      if (enter_wd) begin
         // start first timeout from the load value
         nxt_cnt = reload_ff;
      end else if (wd_mode) begin
         if (good_svc) begin
            nxt_cnt = reload_ff;
         end else if (cfg_ff[wdt_pkg::CFG_EN] && tick) begin
            if (cnt_ff == wdt_pkg::VALUE_ZERO) begin
               expire  = 1'b1;
               nxt_cnt = reload_ff;
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
      end else if (cfg_ff[wdt_pkg::CFG_EN] && tick) begin
         if (cfg_ff[wdt_pkg::CFG_UP]) begin
            if (cnt_ff == wdt_pkg::VALUE_TOP) begin
               expire  = 1'b1;
               nxt_cnt = cfg_ff[wdt_pkg::CFG_PERIODIC] ?
                         reload_ff : wdt_pkg::VALUE_ZERO;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end else begin
            if (cnt_ff == wdt_pkg::VALUE_ZERO) begin
               expire  = 1'b1;
               nxt_cnt = cfg_ff[wdt_pkg::CFG_PERIODIC] ?
                         reload_ff : wdt_pkg::VALUE_TOP;
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
      end
   end

   // counter register
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cnt_ff <= wdt_pkg::VALUE_RST;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // ==========================================================
   // interrupt and chip reset request
   // expiry sets, except watchdog expiry with bit 1 clear; a service write outside watchdog mode clears; set wins the tie
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else if (expire &&
                   (!wd_mode || cfg_ff[wdt_pkg::CFG_IRQ_OPT])) begin
         o_irq <= 1'b1;
      end else if (wr_svc && !wd_mode) begin
         o_irq <= 1'b0;
      end
   end

   // request stays up so the chip reset logic cannot miss it
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_chip_reset <= 1'b0;
      end else if (bad_svc) begin
         o_chip_reset <= 1'b1;
      end else if (expire && wd_mode &&
                   !cfg_ff[wdt_pkg::CFG_IRQ_OPT]) begin
         o_chip_reset <= 1'b1;
      end
   end

   // ==========================================================
   // read port; service register and lfsr read back as zero
   always_ff @(posedge i_mclk) begin
      if (i_rst || !i_rd) begin
         o_rdata <= 32'h00000000;
      end else begin
         case (i_addr)
            wdt_pkg::RELOAD_ADDR: o_rdata <= 32'(reload_ff);
            wdt_pkg::VALUE_ADDR:  o_rdata <= 32'(cnt_ff);
            wdt_pkg::CONFIG_ADDR: o_rdata <= 32'(cfg_ff);
            default:              o_rdata <= 32'h00000000;
         endcase
      end
   end

   // ==========================================================
   // checks
   cfg_lock_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      wd_mode && (wr_cfg || wr_load) |=>
      $stable(cfg_ff) && $stable(reload_ff))
      else $error("write changed a locked register");

   bad_service_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      wr_svc && secure_on && (i_wdata[7:0] != lfsr_q) |=>
      o_chip_reset)
      else $error("mismatched service did not reset chip");

   zero_seed_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      wr_svc && secure_on && (lfsr_q == 8'h00) |=> o_chip_reset)
      else $error("zero lfsr state did not reset chip");

   good_service_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      good_svc && secure_on |=>
      cnt_ff == reload_ff && lfsr_q != $past(lfsr_q) && !o_chip_reset)
      else $error("matching service did not reload and advance");

   up_count_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      tick && !wd_mode && !wr_cfg && cfg_ff[wdt_pkg::CFG_EN] &&
      cfg_ff[wdt_pkg::CFG_UP] && cnt_ff != 16'hFFFF |=>
      cnt_ff == $past(cnt_ff) + 16'h0001)
      else $error("up count did not step by one");

   stopped_hold_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      (!cfg_ff[wdt_pkg::CFG_EN] && !wd_mode && !wr_cfg) [*2] |->
      $stable(cnt_ff))
      else $error("disabled timer changed its count");

   free_wrap_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      tick && !wd_mode && !wr_cfg && cfg_ff[wdt_pkg::CFG_EN] &&
      !cfg_ff[wdt_pkg::CFG_UP] && !cfg_ff[wdt_pkg::CFG_PERIODIC] &&
      cnt_ff == 16'h0000 |=> cnt_ff == 16'hFFFF ##0 o_irq)
      else $error("free running down count did not wrap");

   wd_expire_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      wd_mode && tick && !good_svc && cfg_ff[wdt_pkg::CFG_EN] &&
      cnt_ff == 16'h0000 |=>
      (cfg_ff[wdt_pkg::CFG_IRQ_OPT] ? o_irq : o_chip_reset))
      else $error("watchdog expiry gave wrong response");

   irq_clear_a: assert property (
      @(posedge i_mclk) disable iff (i_rst)
      wr_svc && !wd_mode && !expire |=> !o_irq)
      else $error("service write did not clear interrupt");
endmodule
`default_nettype wire
